// [logic/dprg_consts.svh]
`ifndef DPRG_CONSTS_SVH
`define DPRG_CONSTS_SVH
// Number of configurable general-purpose pins
`define DPRG_GPIO_N 8
`define DPRG_GPIO_SEL_W 3
// Reset values of the pin map
`define DPRG_RST_MAP_LANE 3'h0
`define DPRG_RST_MAP_EN 3'h3
`define DPRG_RST_MAP_POL 3'h1
`define DPRG_RST_MAP_ADPT 3'h2
// Contract voltage codes
`define DPRG_V5 2'h0
`define DPRG_V9 2'h1
`define DPRG_V15 2'h2
`define DPRG_V20 2'h3
// Adapter presence filter count limit; a change must hold for one cycle more than this
`define DPRG_ADPT_FILT 4'h3
`endif

// [logic/dprg_ctrl.sv]
`timescale 1ns/1ns
`include "dprg_consts.svh"
// Notes on behaviour
// - adapter first: try to become source
// - source first, no adapter: sink, flash powered
// - late adapter: enable source objects, swap roles
// - orientation from CC sets mux polarity
// - support four-lane and two-lane plus USB modes
// - pins drive lane mode and polarity
// - separate pin drives mux enable
// - mux events mappable to any pin
// - adapter presence sampled on a pin input
// - adapter present: no sink request, offer source
// - adapter lost: leave 20 V, renegotiate as sink
// - adapter back: resend source caps, renegotiate
// - regulator enable follows plug event
// - three selects mark 9, 15, 20 V contracts
// - drive matching select; none means 5 V
// - interrupt system controller on state change
module dprg_ctrl
  import dprg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Type-C port status from protocol layer
  input wire logic attach_in,
  input wire logic cc_flip_in,
  input wire logic partner_is_source_in,
  input wire logic alt_mode_active_in,
  input wire logic alt_four_lane_in,
  input wire logic contract_valid_in,
  input wire logic [1:0] contract_volt_in,
  input wire logic hard_reset_in,
  input wire logic swap_done_in,
  // Pin configuration
  input wire logic [2:0] map_lane_in,
  input wire logic [2:0] map_en_in,
  input wire logic [2:0] map_pol_in,
  input wire logic [2:0] map_adapter_in,
  input wire logic map_load_in,
  // General-purpose pins
  input wire logic [`DPRG_GPIO_N-1:0] gpio_in,
  output logic [`DPRG_GPIO_N-1:0] gpio_out,
  output logic [`DPRG_GPIO_N-1:0] gpio_oe,
  // Dedicated outputs
  output logic orientation_out,
  output logic regulator_enable_out,
  output logic select_9v_out,
  output logic select_15v_out,
  output logic select_20v_out,
  // Power path and policy requests
  output logic external_sink_path,
  output logic high_voltage_source_path,
  output logic flash_power_out,
  output logic role_source_out,
  output logic sink_request_allowed_out,
  output logic source_pdo_enable_out,
  output logic swap_request_out,
  output logic send_src_caps_out,
  output logic renegotiate_out,
  output logic irq_out
);
  dprg_state_t state_ff, nxt_state;
  logic [2:0] sel_lane_ff, sel_en_ff, sel_pol_ff, sel_adpt_ff;
  logic adpt_raw_ff, adpt_ff, adpt_prev_ff;
  logic [3:0] adpt_cnt_ff;
  logic [`DPRG_GPIO_N-1:0] pin_val, pin_oe;
  logic lane_ev_ff, en_ev_ff, pol_ev_ff;
  logic [3:0] stat_prev_ff;
  logic adpt_rise, adpt_fall;

  // ----------------------------------------------------------------
  // Pin map configuration
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sel_lane_ff <= `DPRG_RST_MAP_LANE;
      sel_en_ff <= `DPRG_RST_MAP_EN;
      sel_pol_ff <= `DPRG_RST_MAP_POL;
      sel_adpt_ff <= `DPRG_RST_MAP_ADPT;
    end else if (map_load_in) begin
      sel_lane_ff <= map_lane_in;
      sel_en_ff <= map_en_in;
      sel_pol_ff <= map_pol_in;
      sel_adpt_ff <= map_adapter_in;
    end
  end

  // ----------------------------------------------------------------
  // Adapter presence sampling
  // ----------------------------------------------------------------
  // Short filter so a bouncing barrel jack does not trigger swaps
  always_ff @(posedge clk) begin
    if (!resetn) begin
      adpt_raw_ff <= 1'b0;
      adpt_cnt_ff <= 4'h0;
      adpt_ff <= 1'b0;
      adpt_prev_ff <= 1'b0;
    end else begin
      adpt_raw_ff <= gpio_in[sel_adpt_ff];
      adpt_prev_ff <= adpt_ff;
      if (adpt_raw_ff == adpt_ff) begin
        adpt_cnt_ff <= 4'h0;
      end else if (adpt_cnt_ff == `DPRG_ADPT_FILT) begin
        adpt_ff <= adpt_raw_ff;
        adpt_cnt_ff <= 4'h0;
      end else begin
        adpt_cnt_ff <= adpt_cnt_ff + 4'h1;
      end
    end
  end
  assign adpt_rise = adpt_ff & ~adpt_prev_ff;
  assign adpt_fall = ~adpt_ff & adpt_prev_ff;

  // ----------------------------------------------------------------
  // Power role state machine
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      DPRG_IDLE: begin
        if (attach_in) begin
          if (adpt_ff) begin
            nxt_state = DPRG_SRC;
          end else if (partner_is_source_in) begin
            nxt_state = DPRG_SNK;
          end
        end
      end
      DPRG_SNK: begin
        if (adpt_rise) begin
          nxt_state = DPRG_SWAP;
        end
      end
      DPRG_SWAP: begin
        // Adapter lost mid-swap: stay sink, never source without it
        if (adpt_fall) begin
          nxt_state = DPRG_SNK;
        end else if (swap_done_in) begin
          nxt_state = DPRG_SRC;
        end
      end
      DPRG_SRC: begin
        if (adpt_fall) begin
          nxt_state = DPRG_RENEG;
        end
      end
      DPRG_RENEG: begin
        if (adpt_rise) begin
          nxt_state = DPRG_SRC;
        end else if (contract_valid_in) begin
          nxt_state = DPRG_SNK;
        end
      end
      default: nxt_state = DPRG_IDLE;
    endcase
    if (!attach_in) begin
      nxt_state = DPRG_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_ff <= DPRG_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // Policy outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      role_source_out <= 1'b0;
      sink_request_allowed_out <= 1'b0;
      source_pdo_enable_out <= 1'b0;
      swap_request_out <= 1'b0;
      send_src_caps_out <= 1'b0;
      renegotiate_out <= 1'b0;
      external_sink_path <= 1'b0;
      high_voltage_source_path <= 1'b0;
      flash_power_out <= 1'b0;
    end else begin
      role_source_out <= (nxt_state == DPRG_SRC);
      sink_request_allowed_out <= !adpt_ff;
      source_pdo_enable_out <= adpt_ff;
      swap_request_out <= (state_ff == DPRG_SNK)
                          && (nxt_state == DPRG_SWAP);
      send_src_caps_out <= (state_ff == DPRG_RENEG)
                           && (nxt_state == DPRG_SRC);
      renegotiate_out <= (state_ff == DPRG_SRC)
                         && (nxt_state == DPRG_RENEG);
      external_sink_path <= (nxt_state == DPRG_SNK);
      high_voltage_source_path <= (nxt_state == DPRG_SRC);
      // Flash always powered from VBUS or adapter; needed for code load
      flash_power_out <= attach_in | adpt_ff;
    end
  end

  // ----------------------------------------------------------------
  // Mux control
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      lane_ev_ff <= 1'b0;
      en_ev_ff <= 1'b0;
      pol_ev_ff <= 1'b0;
      orientation_out <= 1'b0;
      gpio_out <= '0;
      gpio_oe <= '0;
    end else begin
      // High selects four-lane; low two-lane plus USB
      lane_ev_ff <= alt_mode_active_in & alt_four_lane_in;
      en_ev_ff <= attach_in;
      pol_ev_ff <= attach_in & cc_flip_in;
      orientation_out <= attach_in & cc_flip_in;
      gpio_out <= pin_val;
      gpio_oe <= pin_oe;
    end
  end

  dprg_pin_map u_map (
    .lane_ev(lane_ev_ff),
    .en_ev(en_ev_ff),
    .pol_ev(pol_ev_ff),
    .sel_lane(sel_lane_ff),
    .sel_en(sel_en_ff),
    .sel_pol(sel_pol_ff),
    .pin_val(pin_val),
    .pin_oe(pin_oe)
  );

  // ----------------------------------------------------------------
  // Regulator and voltage selects
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      regulator_enable_out <= 1'b0;
      select_9v_out <= 1'b0;
      select_15v_out <= 1'b0;
      select_20v_out <= 1'b0;
    end else begin
      regulator_enable_out <= attach_in;
      // One-hot decode guarantees at most one select
      if (!attach_in || hard_reset_in || !adpt_ff
          || nxt_state != DPRG_SRC || !contract_valid_in) begin
        select_9v_out <= 1'b0;
        select_15v_out <= 1'b0;
        select_20v_out <= 1'b0;
      end else begin
        select_9v_out <= contract_volt_in == `DPRG_V9;
        select_15v_out <= contract_volt_in == `DPRG_V15;
        select_20v_out <= contract_volt_in == `DPRG_V20;
      end
    end
  end

  // ----------------------------------------------------------------
  // System controller interrupt
  // ----------------------------------------------------------------
  // Firmware image transfer is handled by the I2C slave, not here
  always_ff @(posedge clk) begin
    if (!resetn) begin
      stat_prev_ff <= 4'h0;
      irq_out <= 1'b0;
    end else begin
      stat_prev_ff <= {attach_in, adpt_ff, contract_valid_in,
                       state_ff == DPRG_SRC};
      irq_out <= stat_prev_ff != {attach_in, adpt_ff, contract_valid_in,
                                  state_ff == DPRG_SRC};
    end
  end
endmodule // dprg_ctrl

// [logic/dprg_pin_map.sv]
`timescale 1ns/1ns
`include "dprg_consts.svh"
// Routes three mux control events onto any of the general-purpose pins
module dprg_pin_map
  import dprg_pkg::*;
(
  // Events
  input wire logic lane_ev,
  input wire logic en_ev,
  input wire logic pol_ev,
  // Pin selection
  input wire logic [`DPRG_GPIO_SEL_W-1:0] sel_lane,
  input wire logic [`DPRG_GPIO_SEL_W-1:0] sel_en,
  input wire logic [`DPRG_GPIO_SEL_W-1:0] sel_pol,
  // Pin drive
  output logic [`DPRG_GPIO_N-1:0] pin_val,
  output logic [`DPRG_GPIO_N-1:0] pin_oe
);
  genvar i;
  generate
    for (i = 0; i < `DPRG_GPIO_N; i++) begin : g_pin
      localparam logic [`DPRG_GPIO_SEL_W-1:0] pin_idx = `DPRG_GPIO_SEL_W'(i);
      // Lane mode wins if two events share a pin
      always_comb begin
        pin_oe[i] = (sel_lane == pin_idx) || (sel_en == pin_idx)
                    || (sel_pol == pin_idx);
        if (sel_lane == pin_idx) begin
          pin_val[i] = lane_ev;
        end else if (sel_en == pin_idx) begin
          pin_val[i] = en_ev;
        end else begin
          pin_val[i] = (sel_pol == pin_idx) & pol_ev;
        end
      end
    end
  endgenerate
endmodule // dprg_pin_map

// [logic/dprg_pkg.sv]
package dprg_pkg;
  typedef enum logic [2:0] {
    DPRG_IDLE = 3'b000,
    DPRG_SRC = 3'b001,
    DPRG_SNK = 3'b010,
    DPRG_SWAP = 3'b011,
    DPRG_RENEG = 3'b100
  } dprg_state_t;
  typedef logic [1:0] dprg_volt_t;
endpackage

// [testbench/dprg_ctrl_asserts.sv]
`timescale 1ns/1ns
module dprg_ctrl_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Port status
  input wire logic attach_in,
  input wire logic cc_flip_in,
  input wire logic hard_reset_in,
  input wire logic contract_valid_in,
  input wire logic [1:0] contract_volt_in,
  // Policy outputs
  input wire logic orientation_out,
  input wire logic regulator_enable_out,
  input wire logic select_9v_out,
  input wire logic select_15v_out,
  input wire logic select_20v_out,
  input wire logic role_source_out,
  input wire logic sink_request_allowed_out,
  input wire logic swap_request_out,
  input wire logic renegotiate_out,
  input wire logic irq_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----------------
  // Checks
  // ----------------
  chk_reg_on_plug: assert property ($rose(attach_in) |=>
    regulator_enable_out) else $error("regulator not enabled on plug");
  chk_reg_off_unplug: assert property (!attach_in |=>
    !regulator_enable_out) else $error("regulator on while detached");
  chk_sel_onehot: assert property ($onehot0(
    {select_9v_out, select_15v_out, select_20v_out}))
    else $error("several voltage selects high");
  chk_sel_clear: assert property ((!attach_in || hard_reset_in) |=>
    !(select_9v_out || select_15v_out || select_20v_out))
    else $error("select not cleared");
  chk_sel_9v_cause: assert property (select_9v_out |->
    $past(contract_valid_in) && $past(contract_volt_in) == 2'h1)
    else $error("9 V select without 9 V contract");
  chk_sel_20v_role: assert property (select_20v_out |->
    role_source_out) else $error("20 V select outside source role");
  chk_src_no_sink: assert property (role_source_out |->
    !sink_request_allowed_out) else $error("sink request while source");
  chk_swap_pulse: assert property (swap_request_out |=>
    !swap_request_out) else $error("swap request longer than a cycle");
  chk_reneg_pulse: assert property (renegotiate_out |=>
    !renegotiate_out) else $error("renegotiate longer than a cycle");
  chk_irq_on_plug: assert property ($rose(attach_in) |->
    ##[1:4] irq_out) else $error("no interrupt after plug");
  chk_orient_plug: assert property ($rose(attach_in) |=>
    orientation_out == $past(cc_flip_in)) else $error("orientation wrong");
endmodule // dprg_ctrl_asserts
bind dprg_ctrl dprg_ctrl_asserts i_dprg_ctrl_asserts (.clk, .resetn,
  .attach_in, .cc_flip_in, .hard_reset_in, .contract_valid_in,
  .contract_volt_in, .orientation_out, .regulator_enable_out,
  .select_9v_out, .select_15v_out, .select_20v_out, .role_source_out,
  .sink_request_allowed_out, .swap_request_out, .renegotiate_out, .irq_out);

// [testbench/dprg_partner.sv]
`timescale 1ns/1ns
module dprg_partner (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Test controls
  input wire logic slow,
  input wire logic offer,
  input wire logic [1:0] volt,
  // Policy side
  input wire logic swap_request_out,
  output logic contract_valid_in,
  output logic [1:0] contract_volt_in,
  output logic swap_done_in
);
  logic [3:0] wait_ff;
  // ----------------
  // Role swap answer
  // ----------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wait_ff <= 4'h0;
      swap_done_in <= 1'b0;
    end else begin
      swap_done_in <= (wait_ff == 4'h1);
      if (swap_request_out) begin
        wait_ff <= slow ? 4'hC : 4'h1;
      end else if (wait_ff != 4'h0) begin
        wait_ff <= wait_ff - 4'h1;
      end
    end
  end
  // Voltage code churns while no contract, so it is never trusted stale
  always_ff @(posedge clk) begin
    if (!resetn) begin
      contract_valid_in <= 1'b0;
      contract_volt_in <= 2'h0;
    end else begin
      contract_valid_in <= offer;
      contract_volt_in <= offer ? volt : ~contract_volt_in;
    end
  end
endmodule // dprg_partner

// [testbench/test_dprg_ctrl.sv]
`timescale 1ns/1ns
`include "dprg_consts.svh"
module test_dprg_ctrl;
  logic clk, resetn, attach, flip, psrc, alt_on, alt_four, hrst, slow;
  logic offer, map_load, cv, sd, orient, reg_en, s9, s15, s20, flash;
  logic role, sink_ok, pdo_en, swap_req, caps, reneg, irq;
  logic snk_path, hv_path;
  logic [1:0] volt, cvolt;
  logic [2:0] map_en;
  logic [`DPRG_GPIO_N-1:0] gpio_in, gpio_out, gpio_oe;
  int mismatches, comparisons;
  int cycles = 0;
  wire [3:0] pulses = {swap_req, caps, reneg, irq};
  dprg_partner i_dprg_partner (.clk(clk), .resetn(resetn), .slow(slow),
    .offer(offer), .volt(volt), .swap_request_out(swap_req),
    .contract_valid_in(cv), .contract_volt_in(cvolt), .swap_done_in(sd));
  dprg_ctrl i_dprg_ctrl (.clk(clk), .resetn(resetn), .attach_in(attach),
    .cc_flip_in(flip), .partner_is_source_in(psrc),
    .alt_mode_active_in(alt_on), .alt_four_lane_in(alt_four),
    .contract_valid_in(cv), .contract_volt_in(cvolt),
    .hard_reset_in(hrst), .swap_done_in(sd), .map_lane_in(3'h0),
    .map_en_in(map_en), .map_pol_in(3'h1), .map_adapter_in(3'h2),
    .map_load_in(map_load), .gpio_in(gpio_in), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .orientation_out(orient),
    .regulator_enable_out(reg_en), .select_9v_out(s9),
    .select_15v_out(s15), .select_20v_out(s20),
    .external_sink_path(snk_path),
    .high_voltage_source_path(hv_path), .flash_power_out(flash),
    .role_source_out(role), .sink_request_allowed_out(sink_ok),
    .source_pdo_enable_out(pdo_en), .swap_request_out(swap_req),
    .send_src_caps_out(caps), .renegotiate_out(reneg), .irq_out(irq));
  // ----------------
  // Helpers
  // ----------------
  task automatic chk(input string what, input logic [7:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Bounded wait for a one-cycle pulse, sampled mid-cycle
  task automatic wait_p(input int b, input string what);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 40 && !hit; i++) begin
      @(negedge clk);
      hit = (pulses[b] === 1'b1);
    end
    chk(what, hit, 8'h1);
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      final_report;
    end
  end
  // ----------------
  // Sequence
  // ----------------
  initial begin
    {resetn, attach, alt_on, alt_four, hrst, offer, map_load} = 7'h0;
    {flip, psrc, slow} = 3'h7;
    volt = 2'h0;
    map_en = 3'h3;
    gpio_in = 8'h00;
    mismatches = 0;
    comparisons = 0;
    // Firmware image writes arrive over I2C from the controller
    tick(9);
    resetn = 1'b1;
    attach = 1'b1;
    tick(3);
    chk("flash", flash, 8'h1);
    chk("snk_path", snk_path, 8'h1);
    chk("role", role, 8'h0);
    gpio_in[2] = 1'b1;
    wait_p(3, "swap_req");
    chk("pdo_en", pdo_en, 8'h1);
    tick(5);
    chk("role", role, 8'h0);
    tick(11);
    chk("role", role, 8'h1);
    chk("hv_path", hv_path, 8'h1);
    offer = 1'b1;
    for (int v = 0; v < 4; v++) begin
      volt = v[1:0];
      tick(4);
      chk("sel", {s20, s15, s9}, (v == 0) ? 8'h0 : 8'h1 << (v - 1));
    end
    {alt_on, alt_four} = 2'h3;
    tick(3);
    chk("lane4", gpio_out[0], 8'h1);
    alt_four = 1'b0;
    tick(3);
    chk("lane2", gpio_out[0], 8'h0);
    chk("pol", gpio_out[1], 8'h1);
    chk("orient", orient, 8'h1);
    chk("mux_en", gpio_out[3], 8'h1);
    chk("oe", gpio_oe[3:0], 8'hB);
    hrst = 1'b1;
    tick(2);
    chk("sel_hr", {s20, s15, s9}, 8'h0);
    hrst = 1'b0;
    {offer, gpio_in[2]} = 2'h0;
    wait_p(1, "reneg");
    chk("s20", s20, 8'h0);
    gpio_in[2] = 1'b1;
    wait_p(2, "caps");
    tick(2);
    chk("role", role, 8'h1);
    gpio_in[2] = 1'b0;
    wait_p(1, "reneg");
    offer = 1'b1;
    volt = 2'h0;
    tick(4);
    chk("role", role, 8'h0);
    chk("sink_ok", sink_ok, 8'h1);
    {slow, gpio_in[2]} = 2'h1;
    wait_p(3, "swap_req");
    tick(4);
    chk("role", role, 8'h1);
    chk("sink_ok", sink_ok, 8'h0);
    attach = 1'b0;
    tick(2);
    chk("reg_en", reg_en, 8'h0);
    chk("sel", {s20, s15, s9}, 8'h0);
    {psrc, attach} = 2'h1;
    wait_p(0, "irq");
    chk("role", role, 8'h1);
    chk("reg_en", reg_en, 8'h1);
    {map_en, map_load} = 4'hB;
    tick(1);
    map_load = 1'b0;
    tick(3);
    chk("remap", {gpio_oe[5], gpio_out[5]}, 8'h3);
    flip = 1'b0;
    tick(3);
    chk("orient_n", orient, 8'h0);
    chk("pol_n", gpio_out[1], 8'h0);
    final_report;
  end
endmodule // test_dprg_ctrl
